/* core/pin_function_alarm_trigger.sv */
// pin function muxing, alarm driver and conversion trigger detection
`timescale 1ns/100ps
`default_nettype none

// Contract
// R1 - alarm pin pulled low while any analog channel is out of range
// R2 - each falling trigger edge starts one sampling and conversion
// R3 - interface select high: shared pin is the spi chip select
// R4 - interface select low: shared pin is i2c address bit zero
// R5 - remote one negative pin: diode input when enabled, else gpio
// R6 - remote one positive pin: diode input when enabled, else gpio
// R7 - remote two negative pin: diode input when enabled, else gpio
// R8 - inputs four to fifteen single-ended; only zero to three differential
// R9 - board supplies pull-up on remote pins used as gpio outputs
// R10 - trigger synchronised, falling edge detected once per edge
module pin_function_alarm_trigger
    import pin_alarm_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // alarm
    input wire logic [15:0] i_out_of_range,
    output logic o_alarm_out,
    output logic o_alarm_oe_n,
    // conversion trigger
    input wire logic i_conversion_trigger_n,
    output logic o_convert_start,
    // interface selection
    input wire logic i_spi_select,
    input wire logic i_select_or_addr_bit0,
    input wire logic [6:0] i_addr_upper,
    output logic o_spi_cs_n,
    output logic o_spi_active,
    output logic [6:0] o_i2c_addr,
    // remote sensor pins (order: remote1 neg, remote1 pos, remote2 neg)
    input wire logic i_remote_sensor_one_en,
    input wire logic i_remote_sensor_two_en,
    input wire logic [2:0] i_gpio_out,
    input wire logic [2:0] i_remote_pin_in,
    output logic [2:0] o_remote_pin_out,
    output logic [2:0] o_remote_pin_oe_n,
    output logic [2:0] o_gpio_in,
    output logic [2:0] o_diode_connect,
    // analog input configuration
    input wire logic [3:0] i_diff_request,
    output logic [15:0] o_analog_inputs_diff
);

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic [2:0] trig_sync_r;
    logic [2:0] sel_sync_r;
    logic [2:0] cs_sync_r;
    logic [2:0] pin0_sync_r;
    logic [2:0] pin1_sync_r;
    logic [2:0] pin2_sync_r;
    logic spi_sel_r;
    logic cs_level_r;
    logic [2:0] pin_level_r;

    function automatic logic settle(input logic [2:0] s, input logic held);
        settle = (s[1] == s[2]) ? s[2] : held;
    endfunction

    // R10 trigger synchroniser chain
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            trig_sync_r <= 3'h7;
        end else begin
            trig_sync_r <= {trig_sync_r[1:0], i_conversion_trigger_n};
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sel_sync_r <= 3'h0;
            cs_sync_r <= 3'h7;
            pin0_sync_r <= 3'h7;
            pin1_sync_r <= 3'h7;
            pin2_sync_r <= 3'h7;
            spi_sel_r <= 1'b0;
            cs_level_r <= 1'b1;
            pin_level_r <= 3'h7;
        end else begin
            sel_sync_r <= {sel_sync_r[1:0], i_spi_select};
            cs_sync_r <= {cs_sync_r[1:0], i_select_or_addr_bit0};
            pin0_sync_r <= {pin0_sync_r[1:0], i_remote_pin_in[0]};
            pin1_sync_r <= {pin1_sync_r[1:0], i_remote_pin_in[1]};
            pin2_sync_r <= {pin2_sync_r[1:0], i_remote_pin_in[2]};
            spi_sel_r <= settle(sel_sync_r, spi_sel_r);
            cs_level_r <= settle(cs_sync_r, cs_level_r);
            pin_level_r <= {settle(pin2_sync_r, pin_level_r[2]),
                            settle(pin1_sync_r, pin_level_r[1]),
                            settle(pin0_sync_r, pin_level_r[0])};
        end
    end

    // ------------------------------------------------------------
    // conversion trigger
    // ------------------------------------------------------------
    trig_state_t trig_state_r;
    logic trig_fall;
    assign trig_fall = (trig_sync_r[1] == 1'b0) && (trig_sync_r[2] == 1'b0);

    // R2 R10 one start per falling edge
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            trig_state_r <= TRIG_IDLE;
            o_convert_start <= 1'b0;
        end else begin
            o_convert_start <= 1'b0;
            case (trig_state_r)
                TRIG_IDLE: begin
                    if (trig_fall) begin
                        trig_state_r <= TRIG_LOW;
                        o_convert_start <= 1'b1;
                    end
                end
                TRIG_LOW: begin
                    if (trig_sync_r[1] && trig_sync_r[2]) begin
                        trig_state_r <= TRIG_IDLE;
                    end
                end
                default: begin
                    trig_state_r <= TRIG_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // alarm
    // ------------------------------------------------------------
    // R1 open drain alarm
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_alarm_out <= 1'b0;
            o_alarm_oe_n <= 1'b1;
        end else begin
            o_alarm_out <= 1'b0;
            o_alarm_oe_n <= ~(|i_out_of_range);
        end
    end

    // ------------------------------------------------------------
    // interface select
    // ------------------------------------------------------------
    host_select_t host_nxt;
    always_comb begin
        host_nxt.spi_active = spi_sel_r;
        // R3 spi chip select
        host_nxt.spi_cs_n = spi_sel_r ? cs_level_r : 1'b1;
        // R4 i2c address bit
        host_nxt.i2c_addr = {i_addr_upper[6:1], spi_sel_r ? 1'b0 : cs_level_r};
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_spi_cs_n <= 1'b1;
            o_spi_active <= 1'b0;
            o_i2c_addr <= ADDR_UPPER_RESET;
        end else begin
            o_spi_cs_n <= host_nxt.spi_cs_n;
            o_spi_active <= host_nxt.spi_active;
            o_i2c_addr <= host_nxt.i2c_addr;
        end
    end

    // ------------------------------------------------------------
    // remote sensor pins
    // ------------------------------------------------------------
    logic [2:0] sensor_en;
    gpio_drive_t drive_nxt;
    assign sensor_en = {i_remote_sensor_two_en, i_remote_sensor_one_en, i_remote_sensor_one_en};

    always_comb begin
        // R5 R6 R7 diode pin or gpio; R9 pin drives low only, pull-up external
        drive_nxt.gpio_out = 3'h0;
        drive_nxt.gpio_oe_n = sensor_en | i_gpio_out;
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_remote_pin_out <= 3'h0;
            o_remote_pin_oe_n <= 3'h7;
            o_gpio_in <= 3'h7;
            o_diode_connect <= 3'h0;
        end else begin
            o_remote_pin_out <= drive_nxt.gpio_out;
            o_remote_pin_oe_n <= drive_nxt.gpio_oe_n;
            o_gpio_in <= pin_level_r | sensor_en;
            o_diode_connect <= sensor_en;
        end
    end

    // ------------------------------------------------------------
    // analog input mode
    // ------------------------------------------------------------
    // R8 only low four inputs may be differential
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_analog_inputs_diff <= CHAN_RESET;
        end else begin
            o_analog_inputs_diff <= {12'h000, i_diff_request & DIFF_CAPABLE_MASK};
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_alarm_follows: assert property (@(posedge i_clock) disable iff (i_rst) // R1
        (|i_out_of_range) |=> !o_alarm_oe_n) else $error("alarm not driven low");
    a_alarm_release: assert property (@(posedge i_clock) disable iff (i_rst) // R1
        !(|i_out_of_range) |=> o_alarm_oe_n) else $error("alarm not released");
    a_start_edge: assert property (@(posedge i_clock) disable iff (i_rst) // R2
        ($fell(trig_sync_r[2]) && !trig_sync_r[1] && trig_state_r == TRIG_IDLE) |=> o_convert_start)
        else $error("missed conversion start");
    a_start_single: assert property (@(posedge i_clock) disable iff (i_rst) // R10
        o_convert_start |=> !o_convert_start) else $error("start longer than one cycle");
    a_start_cause: assert property (@(posedge i_clock) disable iff (i_rst) // R10
        o_convert_start |-> !$past(trig_sync_r[2])) else $error("start without low trigger");
    a_cs_spi_mode: assert property (@(posedge i_clock) disable iff (i_rst) // R3
        !spi_sel_r |=> o_spi_cs_n) else $error("chip select active in i2c mode");
    a_addr_bit: assert property (@(posedge i_clock) disable iff (i_rst) // R4
        !spi_sel_r |=> o_i2c_addr[0] == $past(cs_level_r)) else $error("address bit wrong");
    a_remote1_neg: assert property (@(posedge i_clock) disable iff (i_rst) // R5
        i_remote_sensor_one_en |=> o_remote_pin_oe_n[0] && o_diode_connect[0]) else $error("remote1 neg driven");
    a_remote1_pos: assert property (@(posedge i_clock) disable iff (i_rst) // R6
        i_remote_sensor_one_en |=> o_remote_pin_oe_n[1] && o_diode_connect[1]) else $error("remote1 pos driven");
    a_remote2_neg: assert property (@(posedge i_clock) disable iff (i_rst) // R7
        (!i_remote_sensor_two_en && !i_gpio_out[2]) |=> !o_remote_pin_oe_n[2]) else $error("gpio low not driven");
    a_single_ended: assert property (@(posedge i_clock) disable iff (i_rst) // R8
        o_analog_inputs_diff[15:4] == 12'h000) else $error("high input marked differential");

    c_conversion: cover property (@(posedge i_clock) disable iff (i_rst) o_convert_start);
    c_alarm: cover property (@(posedge i_clock) disable iff (i_rst) !o_alarm_oe_n);
    c_spi_select: cover property (@(posedge i_clock) disable iff (i_rst) o_spi_active && !o_spi_cs_n);
    c_gpio_drive: cover property (@(posedge i_clock) disable iff (i_rst) !o_remote_pin_oe_n[0]);

endmodule // pin_function_alarm_trigger
`default_nettype wire

/* pkg/pin_alarm_pkg.sv */
// shared constants and carrier types for the pin function and alarm block
`default_nettype none
package pin_alarm_pkg;
    localparam int NUM_CHANNELS = 16;
    localparam int NUM_DIFF_CAPABLE = 4;
    localparam int NUM_REMOTE_PINS = 3;
    localparam int SYNC_STAGES = 3;
    localparam logic [15:0] CHAN_RESET = 16'h0000;
    localparam logic [3:0] DIFF_RESET = 4'h0;
    localparam logic [6:0] ADDR_UPPER_RESET = 7'h00;
    // capability mask: only inputs 0..3 may be paired differentially
    localparam logic [3:0] DIFF_CAPABLE_MASK = 4'hF;

    typedef enum {TRIG_IDLE, TRIG_LOW} trig_state_t;

    // per remote pin: output level and output enable (low = drive low)
    typedef struct packed {
        logic [2:0] gpio_out;
        logic [2:0] gpio_oe_n;
    } gpio_drive_t;

    typedef struct packed {
        logic       spi_cs_n;
        logic       spi_active;
        logic [6:0] i2c_addr;
    } host_select_t;
endpackage
`default_nettype wire

/* sim/remote_pin_board.sv */
// board model: pull-ups on the open-drain alarm and remote pins
`timescale 1ns/100ps
`default_nettype none
module remote_pin_board (
    // pins driven by the device
    input wire logic i_alarm_oe_n,
    input wire logic [2:0] i_pin_out,
    input wire logic [2:0] i_pin_oe_n,
    // other board parts pulling a pin low
    input wire logic [2:0] i_ext_low,
    // resolved wire levels
    output logic o_alarm_level,
    output logic [2:0] o_pin_level
);
    assign o_alarm_level = i_alarm_oe_n;
    assign o_pin_level = ~((~i_pin_oe_n & ~i_pin_out) | i_ext_low);
endmodule // remote_pin_board
`default_nettype wire

/* sim/tb_pin_function_alarm_trigger.sv */
// self-checking bench for the pin function, alarm and trigger block
`timescale 1ns/100ps
`default_nettype none
module tb_pin_function_alarm_trigger;
    import pin_alarm_pkg::*;
    logic clk = 1'b0, rst = 1'b1, trig_n = 1'b1, spi_sel = 1'b0, shared = 1'b0, en1 = 1'b0, en2 = 1'b0;
    logic [15:0] oor = 16'h0000;
    logic [6:0] upper = 7'h00;
    logic [2:0] gout = 3'h0, ext_low = 3'h0;
    logic [3:0] diff_req = 4'h0;
    logic alarm_out, alarm_oe_n, alarm_lvl, conv, cs_n, spi_act;
    logic [6:0] addr;
    logic [2:0] pin_out, pin_oe_n, gin, diode, pin_lvl;
    logic [15:0] diff;
    integer seed = 32'hE4153972;
    int bad_count = 0, n_checks = 0, cycles = 0, starts = 0;
    int exp_q[$];

    always #10 clk = ~clk;

    pin_function_alarm_trigger dut (.i_clock(clk), .i_rst(rst), .i_out_of_range(oor),
        .o_alarm_out(alarm_out), .o_alarm_oe_n(alarm_oe_n), .i_conversion_trigger_n(trig_n),
        .o_convert_start(conv), .i_spi_select(spi_sel), .i_select_or_addr_bit0(shared),
        .i_addr_upper(upper), .o_spi_cs_n(cs_n), .o_spi_active(spi_act), .o_i2c_addr(addr),
        .i_remote_sensor_one_en(en1), .i_remote_sensor_two_en(en2), .i_gpio_out(gout),
        .i_remote_pin_in(pin_lvl), .o_remote_pin_out(pin_out), .o_remote_pin_oe_n(pin_oe_n),
        .o_gpio_in(gin), .o_diode_connect(diode), .i_diff_request(diff_req),
        .o_analog_inputs_diff(diff));

    remote_pin_board board (.i_alarm_oe_n(alarm_oe_n), .i_pin_out(pin_out), .i_pin_oe_n(pin_oe_n),
        .i_ext_low(ext_low), .o_alarm_level(alarm_lvl), .o_pin_level(pin_lvl));

    task automatic check(input logic [15:0] seen, input logic [15:0] expv);
        n_checks++;
        if (seen !== expv) begin
            bad_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic wrap_up();
        if (bad_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // trigger low for the given cycles, then high long enough to rearm
    task automatic pulse(input int low);
        trig_n = 1'b0;
        repeat (low) @(negedge clk);
        trig_n = 1'b1;
        repeat (5) @(negedge clk);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // start monitor: each pulse takes the oldest note
    // ----------------------------------------
    always @(negedge clk) begin
        if (conv === 1'b1) begin
            if (exp_q.size() == 0) check(16'h0001, 16'h0000);
            else check(16'(starts), 16'(exp_q.pop_front()));
            starts++;
        end
    end

    initial begin
        logic e, eo;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check({14'h0000, alarm_lvl, alarm_out}, 16'h0002);
        check(diff, 16'h0000);
        for (int i = 0; i < 12; i++) begin
            oor = (i % 3 == 0) ? 16'h0000 : (i == 1) ? 16'h8000 : 16'($random(seed));
            repeat (2) @(negedge clk);
            check(alarm_lvl, oor == 16'h0000);
        end
        for (int k = 0; k < 4; k++) begin
            exp_q.push_back(k);
            pulse(3 + k);
        end
        pulse(1);
        repeat (6) @(negedge clk);
        check(16'(starts), 16'h0004);
        for (int m = 0; m < 4; m++) begin
            spi_sel = m[1];
            shared = m[0];
            upper = 7'($random(seed));
            repeat (7) @(negedge clk);
            check({spi_act, cs_n}, m[1] ? {1'b1, m[0]} : 2'b01);
            check(addr, {upper[6:1], m[1] ? 1'b0 : m[0]});
        end
        for (int r = 0; r < 12; r++) begin
            {en1, en2, gout, ext_low} = 8'($random(seed));
            repeat (8) @(negedge clk);
            check(pin_out, 3'h0);
            for (int p = 0; p < 3; p++) begin
                e = (p < 2) ? en1 : en2;
                eo = e | gout[p];
                check({diode[p], pin_oe_n[p]}, {e, eo});
                check(gin[p], e | (eo & ~ext_low[p]));
            end
        end
        for (int d = 0; d < 6; d++) begin
            diff_req = 4'($random(seed));
            repeat (2) @(negedge clk);
            check(diff, {12'h000, diff_req});
        end
        wrap_up();
    end
endmodule // tb_pin_function_alarm_trigger
`default_nettype wire
